// File: design/seq_map_memory.v
/*
  Sequencer character map, memory mode and extended lock registers,
  reached over the index/data I/O port pair, plus the host plane
  steering that memory mode controls.
  Assumes: index/data strobes are single-cycle pulses synchronous to
  ref_clk; the sequencer reset and plane mask registers live elsewhere
  and are presented as plain inputs; graphics read-map select likewise.
*/
// Operation
// - Attribute bit 3 picks primary font (0) or secondary font (1) in text mode.
// - Primary base = {bit1,bit0,bit4} times 8K, 0K to 56K.
// - Secondary base = {bit3,bit2,bit5} times 8K, same encoding.
// - Character map clears on sequencer async reset and on system reset.
// - That async reset fires when sequencer reset bit 0 goes 1 to 0.
// - Chain-4 set: host address bits 1:0 select the single plane.
// - Chain-4 writes reach that plane only if plane write mask enables it.
// - Chain-4 reads ignore read-map select, use host address bits 1:0.
// - Odd/even: address bit 0 picks planes 0,2 (0) or 1,3 (1).
// - Odd/even write enables are plane pair ANDed with write mask.
// - Odd/even reads use read-map bit 1 with address bit 0; map bit 0 ignored.
// - Memory mode bit 1 flags 64K (0) or 256K (1) display memory.
// - Memory mode bits 7-4 and 0 read as zero.
// - Memory mode resets to 04h; character map and lock to 00h.
// - Writing 57h to lock unlocks extended registers; other values lock.
// - Lock reads return 0 when locked, 1 when unlocked.
`timescale 1ns/10ps
`include "seq_map_regs.vh"
module seq_map_memory (
  input wire ref_clk,
  input wire rst,
  input wire index_wr,
  input wire data_wr,
  input wire data_rd,
  input wire [7:0] wr_data,
  input wire [7:0] sequencer_reset_reg,
  input wire [3:0] plane_write_mask_reg,
  input wire [1:0] read_plane_select_reg,
  input wire [1:0] host_addr_low_pair,
  input wire text_attr_bit3,
  input wire ext_reg_wr,
  output reg [7:0] rd_data,
  output reg [7:0] index_out,
  output reg [2:0] primary_font_select,
  output reg [2:0] secondary_font_select,
  output reg [15:0] font_base_addr,
  output reg quad_plane_chain,
  output reg odd_even_mode,
  output reg large_video_memory,
  output reg [3:0] plane_write_en,
  output reg [1:0] read_plane,
  output reg ext_unlocked,
  output reg ext_wr_allowed
);
  reg [7:0] index_reg;
  reg [7:0] font_sel_reg;
  reg [7:0] mem_mode_reg;
  reg unlocked_reg;
  reg async_prev_reg;
  reg [7:0] rd_next;
  reg [7:0] font_next;
  reg [3:0] wen_next;
  reg [1:0] rplane_next;
  reg [2:0] pri_next;
  reg [2:0] sec_next;
  wire async_sequencer_clear;
  wire host_addr_bit0;
  wire wr_font;
  wire wr_mode;
  wire wr_lock;

  assign host_addr_bit0 = host_addr_low_pair[0];
  // Falling edge of the sequencer reset bit 0
  assign async_sequencer_clear = async_prev_reg & ~sequencer_reset_reg[`BIT_ASYNC_CLR];
  assign wr_font = data_wr && (index_reg == `IDX_FONT_SEL);
  assign wr_mode = data_wr && (index_reg == `IDX_MEM_MODE);
  assign wr_lock = data_wr && (index_reg == `IDX_LOCK);

  always @(posedge ref_clk) begin
    if (rst) begin
      async_prev_reg <= 1'b0;
    end else begin
      async_prev_reg <= sequencer_reset_reg[`BIT_ASYNC_CLR];
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      index_reg <= 8'h00;
    end else if (index_wr) begin
      index_reg <= wr_data;
    end
  end

  // Clear beats a same-cycle write, so software never sees a stale map
  always @* begin
    font_next = font_sel_reg;
    if (async_sequencer_clear) begin
      font_next = `RST_FONT_SEL;
    end else if (wr_font) begin
      font_next = wr_data & `FONT_SEL_MASK;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      font_sel_reg <= `RST_FONT_SEL;
      mem_mode_reg <= `RST_MEM_MODE;
      unlocked_reg <= 1'b0;
    end else begin
      font_sel_reg <= font_next;
      if (wr_mode) begin
        mem_mode_reg <= wr_data & `MEM_MODE_MASK;
      end
      if (wr_lock) begin
        unlocked_reg <= (wr_data == `UNLOCK_KEY);
      end
    end
  end

  always @* begin
    rd_next = 8'h00;
    case (index_reg)
      `IDX_FONT_SEL: begin
        rd_next = font_sel_reg;
      end
      `IDX_MEM_MODE: begin
        rd_next = mem_mode_reg & `MEM_MODE_MASK;
      end
      `IDX_LOCK: begin
        rd_next = {7'h00, unlocked_reg};
      end
      default: begin
        rd_next = 8'h00;
      end
    endcase
  end

  // Font block fields are scattered: low bit sits above the two high bits
  always @* begin
    pri_next = {font_next[1], font_next[0], font_next[4]};
    sec_next = {font_next[3], font_next[2], font_next[5]};
  end

  always @* begin
    wen_next = plane_write_mask_reg;
    rplane_next = read_plane_select_reg;
    if (mem_mode_reg[`BIT_QUAD_CHAIN]) begin
      wen_next = plane_write_mask_reg & (4'h1 << host_addr_low_pair);
      rplane_next = host_addr_low_pair;
    end else if (!mem_mode_reg[`BIT_ODD_EVEN_N]) begin
      wen_next = plane_write_mask_reg & (host_addr_bit0 ? 4'hA : 4'h5);
      rplane_next = {read_plane_select_reg[1], host_addr_bit0};
    end
  end

  // Outputs registered; plane steering lags its address inputs by one cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= 8'h00;
      index_out <= 8'h00;
      primary_font_select <= 3'h0;
      secondary_font_select <= 3'h0;
      font_base_addr <= 16'h0000;
      quad_plane_chain <= 1'b0;
      odd_even_mode <= 1'b0;
      large_video_memory <= 1'b0;
      plane_write_en <= 4'h0;
      read_plane <= 2'h0;
      ext_unlocked <= 1'b0;
      ext_wr_allowed <= 1'b0;
    end else begin
      if (data_rd) begin
        rd_data <= rd_next;
      end
      index_out <= index_reg;
      primary_font_select <= pri_next;
      secondary_font_select <= sec_next;
      // Base is the block number times 8K
      if (text_attr_bit3) begin
        font_base_addr <= {sec_next, 13'h0000};
      end else begin
        font_base_addr <= {pri_next, 13'h0000};
      end
      quad_plane_chain <= mem_mode_reg[`BIT_QUAD_CHAIN];
      odd_even_mode <= ~mem_mode_reg[`BIT_ODD_EVEN_N];
      large_video_memory <= mem_mode_reg[`BIT_LARGE_MEM];
      plane_write_en <= wen_next;
      read_plane <= rplane_next;
      ext_unlocked <= (wr_lock) ? (wr_data == `UNLOCK_KEY) : unlocked_reg;
      ext_wr_allowed <= ext_reg_wr & unlocked_reg;
    end
  end
endmodule

// File: include/seq_map_regs.vh
/*
  Constants for the sequencer font, memory-mode and lock registers:
  index offsets, field positions, reset values and key.
  Assumes inclusion by bare name from design files.
*/
`ifndef SEQ_MAP_REGS_VH
`define SEQ_MAP_REGS_VH
`define IDX_SEQ_RESET 8'h00
`define IDX_PLANE_MASK 8'h02
`define IDX_FONT_SEL 8'h03
`define IDX_MEM_MODE 8'h04
`define IDX_LOCK 8'h06
`define RST_FONT_SEL 8'h00
`define RST_MEM_MODE 8'h04
`define RST_LOCK 8'h00
`define UNLOCK_KEY 8'h57
`define BIT_QUAD_CHAIN 3
`define BIT_ODD_EVEN_N 2
`define BIT_LARGE_MEM 1
`define MEM_MODE_MASK 8'h0E
`define FONT_SEL_MASK 8'h3F
`define BIT_ASYNC_CLR 0
`define BIT_ATTR_FONT 3
`define FONT_BLOCK_SHIFT 13
`endif

// File: test/seq_map_monitor.sv
/* Port assertions for seq_map_memory.
   Assumes the bind below and a single clock domain. */
`timescale 1ns/10ps
module seq_map_monitor (
  input logic ref_clk,
  input logic rst,
  input logic data_rd,
  input logic [7:0] index_out,
  input logic [7:0] rd_data,
  input logic [7:0] sequencer_reset_reg,
  input logic [3:0] plane_write_mask_reg,
  input logic [1:0] read_plane_select_reg,
  input logic [1:0] host_addr_low_pair,
  input logic [2:0] primary_font_select,
  input logic [2:0] secondary_font_select,
  input logic quad_plane_chain,
  input logic odd_even_mode,
  input logic [3:0] plane_write_en,
  input logic [1:0] read_plane,
  input logic ext_unlocked,
  input logic text_attr_bit3,
  input logic ext_reg_wr,
  input logic [15:0] font_base_addr,
  input logic large_video_memory,
  input logic ext_wr_allowed
);
  logic [3:0] mask_d;
  logic [1:0] addr_d, rsel_d;
  logic rst_d, attr_d, ewr_d;
  // Steering outputs lag their inputs by one cycle
  always @(posedge ref_clk) begin
    mask_d <= plane_write_mask_reg;
    addr_d <= host_addr_low_pair;
    rsel_d <= read_plane_select_reg;
    rst_d <= rst;
    attr_d <= text_attr_bit3;
    ewr_d <= ext_reg_wr;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Index copy lags the index by one cycle, so match it on the answer edge
  property p_lk; data_rd ##1 index_out == 8'h06 |-> rd_data == {7'h00, ext_unlocked}; endproperty
  a_lk: assert property (p_lk) else $error("lock read");
  property p_mm; data_rd ##1 index_out == 8'h04 |-> (rd_data & 8'hF1) == 8'h00; endproperty
  a_mm: assert property (p_mm) else $error("mode read");
  property p_mb;
    data_rd ##1 index_out == 8'h04 |->
      rd_data[3:1] == {quad_plane_chain, !odd_even_mode, large_video_memory};
  endproperty
  a_mb: assert property (p_mb) else $error("mode bits");
  property p_fb;
    !rst_d |-> font_base_addr ==
      {(attr_d ? secondary_font_select : primary_font_select), 13'h0000};
  endproperty
  a_fb: assert property (p_fb) else $error("font base");
  property p_ew; !rst_d |-> ext_wr_allowed == (ewr_d && $past(ext_unlocked)); endproperty
  a_ew: assert property (p_ew) else $error("ext write gate");
  property p_cw; !rst_d && quad_plane_chain |-> plane_write_en == (mask_d & (4'h1 << addr_d)); endproperty
  a_cw: assert property (p_cw) else $error("chain write");
  property p_cr; !rst_d && quad_plane_chain |-> read_plane == addr_d; endproperty
  a_cr: assert property (p_cr) else $error("chain read");
  property p_ow; !rst_d && odd_even_mode && !quad_plane_chain |-> plane_write_en == (mask_d & (addr_d[0] ? 4'hA : 4'h5)); endproperty
  a_ow: assert property (p_ow) else $error("pair write");
  property p_or; !rst_d && odd_even_mode && !quad_plane_chain |-> read_plane == {rsel_d[1], addr_d[0]}; endproperty
  a_or: assert property (p_or) else $error("pair read");
  property p_pw; !rst_d && !odd_even_mode && !quad_plane_chain |-> plane_write_en == mask_d; endproperty
  a_pw: assert property (p_pw) else $error("plain write");
  property p_fc; $fell(sequencer_reset_reg[0]) |-> ##[1:3] primary_font_select == 3'h0 && secondary_font_select == 3'h0; endproperty
  a_fc: assert property (p_fc) else $error("font clear");
endmodule
bind seq_map_memory seq_map_monitor mon (.*);

// File: test/seq_map_memory_bench.sv
/* Bench for seq_map_memory: register reads queued, checked on answer.
   Assumes the monitor file is compiled alongside. */
`timescale 1ns/10ps
module seq_map_memory_bench;
  logic ref_clk, rst, index_wr, data_wr, data_rd, text_attr_bit3, ext_reg_wr, rd_seen;
  logic [7:0] wr_data, sequencer_reset_reg, rd_data;
  logic [3:0] plane_write_mask_reg;
  logic [1:0] read_plane_select_reg, host_addr_low_pair;
  logic [31:0] rnd;
  logic [7:0] exp_q [$];
  logic [7:0] modes [3] = '{8'h0A, 8'h02, 8'h06};
  int errors, tests_run, cycles, seed;
  seq_map_memory DUT (.*, .index_out(), .primary_font_select(), .secondary_font_select(),
    .font_base_addr(), .quad_plane_chain(), .odd_even_mode(), .large_video_memory(),
    .plane_write_en(), .read_plane(), .ext_unlocked(), .ext_wr_allowed());
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic summarize;
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask
  // Index then data access; for reads d is the expected byte
  task automatic acc(input logic [7:0] idx, input logic [7:0] d, input bit rd);
    index_wr = 1;
    wr_data = idx;
    step;
    index_wr = 0;
    data_wr = !rd;
    data_rd = rd;
    wr_data = d;
    if (rd) exp_q.push_back(d);
    step;
    data_wr = 0;
    data_rd = 0;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      summarize;
    end
    if (rd_seen) cmp(rd_data, exp_q.pop_front());
    rd_seen <= rst ? 1'b0 : data_rd;
  end
  initial begin
    seed = 32'h0840;
    rst = 1;
    {index_wr, data_wr, data_rd, text_attr_bit3, ext_reg_wr} = 5'h00;
    {wr_data, plane_write_mask_reg, read_plane_select_reg, host_addr_low_pair} = 16'h0000;
    sequencer_reset_reg = 8'h03;
    repeat (3) step;
    rst = 0;
    acc(8'h04, 8'h04, 1);
    acc(8'h03, 8'h00, 1);
    acc(8'h06, 8'h00, 1);
    $display("reset values done");
    acc(8'h04, 8'hFF, 0);
    acc(8'h04, 8'h0E, 1);
    acc(8'h05, 8'hA5, 0);
    acc(8'h05, 8'h00, 1);
    acc(8'h06, 8'h57, 0);
    acc(8'h06, 8'h01, 1);
    acc(8'h06, 8'h56, 0);
    acc(8'h06, 8'h00, 1);
    acc(8'h03, 8'h19, 0);
    acc(8'h03, 8'h19, 1);
    sequencer_reset_reg = 8'h02;
    repeat (3) step;
    sequencer_reset_reg = 8'h03;
    acc(8'h03, 8'h00, 1);
    $display("register tests done");
    // Distinct fonts and an open lock give the steering checks something to see
    acc(8'h03, 8'h19, 0);
    acc(8'h06, 8'h57, 0);
    foreach (modes[m]) begin
      acc(8'h04, modes[m], 0);
      repeat (16) begin
        rnd = $random(seed);
        {plane_write_mask_reg, read_plane_select_reg, host_addr_low_pair} = rnd[7:0];
        {text_attr_bit3, ext_reg_wr} = rnd[9:8];
        step;
      end
    end
    $display("steering tests done");
    repeat (2) step;
    summarize;
  end
endmodule
